// File: sgd_defs.vh
// Constants for the sixteen-channel grayscale dimmer.
`ifndef SGD_DEFS_VH
`define SGD_DEFS_VH
`define SGD_NCH 16
`define SGD_GS_W 16
`define SGD_CHAIN_W 272
`define SGD_CMD_RESET 16'h02B0
`define SGD_BIT_WDOG 0
`define SGD_BIT_ZSAVE 1
`define SGD_BIT_VTH_LO 2
`define SGD_BIT_VTH_HI 3
`define SGD_BIT_GAIN_LO 4
`define SGD_BIT_GAIN_HI 9
`define SGD_BIT_SYNC 10
`define SGD_BIT_CRST 11
`define SGD_BIT_PWM 12
`define SGD_BIT_INTCK 13
`define SGD_BIT_REXT 14
`define SGD_BIT_FMT 15
`define SGD_CNT_W 5
`define SGD_CLK_HZ 20000000
`define SGD_WDOG_MS 30
`define SGD_WDOG_CYC (`SGD_CLK_HZ / 1000 * `SGD_WDOG_MS)
`define SGD_STAG_NS 16
`define SGD_STAG_CYC 1
`define SGD_INT_DIV 8
`define SGD_SEG_HI 128
`define SGD_SEG_LO 64
`endif

// File: sgd_dimmer.v
// Sixteen-channel grayscale dimmer: serial front end, latches and PWM engine.
// Function
// - Serial input is sampled on each shift clock rising edge while the strobe is low.
// - Zero or one edges under strobe move shift data into holding registers.
// - Two or three edges load holding registers into the pulse generator.
// - Six or seven edges load image and command into the 272-bit chain.
// - Eight or nine edges end readback and return to normal operation.
// - Ten or eleven edges copy the 16-bit shift register to command word.
// - Twelve or thirteen edges reset the frame counter when bit 11 is set.
// - Grayscale timing advances on both edges; a period is 32768 clocks.
// - Odd outputs switch one fixed delay after even outputs, except at shutdown, when they go off one cycle before them.
// - Gain is range bit 9 with unsigned five-bit step in bits 8..4.
// - Six-bit gain field resets to 101011 and accepts any value.
// - Bit 15 picks fifteen or sixteen data latches per frame.
// - Fifteen-latch format: global latch carries channel 0 and loads all.
// - Sixteen-latch format: global latch loads all, captures no data.
// - Each grayscale value is 16 bits, most significant bit first.
// - Bit 14 low forces outputs off while resistor pin reads too low.
// - Bit 13 selects external pin or internal oscillator as grayscale clock.
// - Bit 12 selects adaptive pulse density or plain pulse width.
// - Adaptive mode uses 128 segments if all channels half scale, else 64.
// - Bit 10 low defers global latch to frame end; high applies at once.
// - Bits 3..2 encode the short-detection threshold, reset to zero.
// - Bit 1 high enters power saving while all channels hold zero.
// - Bit 0 high turns outputs off when grayscale clock stalls 30 ms.
`timescale 1ns/1ps
`default_nettype none
`include "sgd_defs.vh"
module sgd_dimmer (
  // Clock and reset.
  input wire ref_clk,
  input wire rstn,
  // Serial link pins.
  input wire latch_strobe,
  input wire serial_in,
  input wire shift_clock,
  input wire grayscale_clock,
  output reg serial_out,
  // Analog status inputs.
  input wire rext_low,
  // Channel outputs, high means sink on.
  output reg [15:0] channel_outputs,
  // Analog control outputs.
  output reg [5:0] global_current_gain,
  output reg [1:0] short_threshold,
  output reg power_save,
  output reg [15:0] command_config
);

  // Two-flop synchronisers; only the second stage and later are read.
  // The third stage only serves edge detection, so a pin edge costs
  // two to three cycles of latency before any decision is made.
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg [3:0] sync3_q;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
    end else begin
      sync1_q <= {grayscale_clock, latch_strobe, serial_in, shift_clock};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  wire dck_rise = sync2_q[0] & ~sync3_q[0];
  wire di_s = sync2_q[1];
  wire lat_s = sync2_q[2];
  wire lat_rise = lat_s & ~sync3_q[2];
  wire lat_fall = ~lat_s & sync3_q[2];
  wire gck_edge = sync2_q[3] ^ sync3_q[3];

  // Shift chain: 16 image bits then the rest for readback of all latches.
  reg [`SGD_CHAIN_W-1:0] chain_q;
  reg [`SGD_CNT_W-1:0] edge_cnt_q;
  reg readback_q;
  reg [15:0] hold_q [0:15];
  reg [15:0] gen_q [0:15];
  reg [4:0] latch_idx_q;
  reg frame_rst_q;
  wire [3:0] inst = edge_cnt_q[4:1];
  wire [3:0] tgt_ch = 4'hF - latch_idx_q[3:0];

  // Two-entry buffer between strobe decoder and generator load.
  // A global latch that meets a full buffer is refused; the host must
  // pace global latches to the frame rate in automatic mode.
  reg [1:0] buf_cnt_q;
  reg buf_slot_q;
  wire buf_in_valid = lat_fall & (inst == 4'h1);
  wire buf_in_ready = (buf_cnt_q != 2'h2);
  wire buf_out_valid = (buf_cnt_q != 2'h0);
  wire frame_end;
  wire buf_out_ready = command_config[`SGD_BIT_SYNC] | frame_end;
  wire buf_pop = buf_out_valid & buf_out_ready;
  wire buf_push = buf_in_valid & buf_in_ready;

  // Flattened holding image for readback, generator image for zero detection.
  wire [255:0] hold_flat;
  wire [255:0] gen_flat;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_flat
      assign hold_flat[g*16 +: 16] = hold_q[g];
      assign gen_flat[g*16 +: 16] = gen_q[g];
    end
  endgenerate

  // Serial front end and strobe instruction decoder.
  integer i;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      chain_q <= {`SGD_CHAIN_W{1'b0}};
      edge_cnt_q <= 5'h00;
      readback_q <= 1'b0;
      latch_idx_q <= 5'h00;
      frame_rst_q <= 1'b0;
      command_config <= `SGD_CMD_RESET;
      for (i = 0; i < 16; i = i + 1) begin
        hold_q[i] <= 16'h0000;
      end
    end else begin
      frame_rst_q <= 1'b0;
      if (dck_rise && !lat_s) begin
        // MSB first; chain feeds the next device in a cascade.
        // Edges under the strobe only count the instruction; shifting
        // them in too would push the word out of the low sixteen bits.
        chain_q <= {chain_q[`SGD_CHAIN_W-2:0], di_s};
      end
      if (dck_rise && lat_s && edge_cnt_q != 5'h1F) begin
        // Saturate so a long burst cannot wrap onto a real instruction.
        edge_cnt_q <= edge_cnt_q + 5'h01;
      end
      if (lat_rise) begin
        edge_cnt_q <= 5'h00;
      end
      if (lat_fall) begin
        // Decode at strobe fall so the full edge count is known.
        // Counts of four, five and fourteen upward fall to the default
        // branch and change nothing.
        case (inst)
          4'h0: begin
            hold_q[tgt_ch] <= chain_q[15:0];
            if (latch_idx_q != 5'h0F) begin
              latch_idx_q <= latch_idx_q + 5'h01;
            end
          end
          4'h1: begin
            // Short format: the global latch also carries channel 0.
            if (!command_config[`SGD_BIT_FMT]) begin
              hold_q[0] <= chain_q[15:0];
            end
            latch_idx_q <= 5'h00;
          end
          4'h3: begin
            chain_q <= {hold_flat, command_config};
            readback_q <= 1'b1;
          end
          4'h4: readback_q <= 1'b0;
          4'h5: command_config <= chain_q[15:0];
          4'h6: frame_rst_q <= command_config[`SGD_BIT_CRST];
          default: readback_q <= readback_q;
        endcase
      end
    end
  end

  // Snapshot buffer: up to two pending image copies; a third global latch is refused.
  // The copy is taken at push time, so later data latches for the next
  // frame cannot disturb an image that is still waiting for the generator.
  reg [255:0] snap_q [0:1];
  always @(posedge ref_clk) begin
    if (!rstn) begin
      buf_cnt_q <= 2'h0;
      buf_slot_q <= 1'b0;
      snap_q[0] <= 256'h0;
      snap_q[1] <= 256'h0;
    end else begin
      if (buf_push) begin
        snap_q[buf_slot_q ^ buf_cnt_q[0]] <= command_config[`SGD_BIT_FMT] ?
          hold_flat : {hold_flat[255:16], chain_q[15:0]};
      end
      if (buf_pop) begin
        buf_slot_q <= ~buf_slot_q;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // Generator load from the buffer head.
  // A loop index of its own keeps this process from sharing a variable
  // with the front end.
  integer j;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      for (j = 0; j < 16; j = j + 1) begin
        gen_q[j] <= 16'h0000;
      end
    end else if (buf_pop) begin
      for (j = 0; j < 16; j = j + 1) begin
        gen_q[j] <= snap_q[buf_slot_q][j*16 +: 16];
      end
    end
  end

  // Internal oscillator stand-in: divided enable pulse from ref_clk.
  // Limitation: the rate is a fixed divide of the system clock and does
  // not track supply voltage the way an on-chip oscillator would.
  reg [2:0] osc_q;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      osc_q <= 3'h0;
    end else begin
      osc_q <= osc_q + 3'h1;
    end
  end
  wire gs_tick = command_config[`SGD_BIT_INTCK] ? (osc_q == 3'h7) :
    gck_edge;

  // Grayscale counter: 16 bits, one step per clock edge, so 32768 cycles.
  // Counting both edges halves the clock rate the host must supply for
  // a given refresh, which is the point of the double-edge scheme.
  reg [15:0] gs_cnt_q;
  assign frame_end = gs_tick & (gs_cnt_q == 16'hFFFF);
  always @(posedge ref_clk) begin
    if (!rstn) begin
      gs_cnt_q <= 16'h0000;
    end else if (frame_rst_q) begin
      gs_cnt_q <= 16'h0000;
    end else if (gs_tick) begin
      gs_cnt_q <= gs_cnt_q + 16'h0001;
    end
  end

  // Grayscale clock watchdog; stall sets a sticky flag that turns all outputs off.
  // Any grayscale edge or clearing the enable bit releases the flag, so
  // outputs recover on their own once the clock runs again.
  reg [19:0] wdog_q;
  reg wdog_trip_q;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      wdog_q <= 20'h00000;
      wdog_trip_q <= 1'b0;
    end else if (gck_edge || !command_config[`SGD_BIT_WDOG]) begin
      wdog_q <= 20'h00000;
      wdog_trip_q <= 1'b0;
    end else if (wdog_q >= `SGD_WDOG_CYC) begin
      wdog_trip_q <= 1'b1;
    end else begin
      wdog_q <= wdog_q + 20'h00001;
    end
  end

  // Adaptive mode: all channels at half scale uses 128 segments, else 64.
  // Each segment carries an equal share; the bit rotation spreads pulses.
  wire all_half = &{gen_q[0][15], gen_q[1][15], gen_q[2][15], gen_q[3][15],
    gen_q[4][15], gen_q[5][15], gen_q[6][15], gen_q[7][15],
    gen_q[8][15], gen_q[9][15], gen_q[10][15], gen_q[11][15],
    gen_q[12][15], gen_q[13][15], gen_q[14][15], gen_q[15][15]};
  // Limitation: no width correction for slow output transients is made.
  wire [15:0] adaptive_pulse_density_pos = all_half ?
    {gs_cnt_q[6:0], gs_cnt_q[15:7]} : {gs_cnt_q[5:0], gs_cnt_q[15:6]};
  wire [15:0] cmp_pos = command_config[`SGD_BIT_PWM] ? gs_cnt_q :
    adaptive_pulse_density_pos;

  // Resistor-pin comparator comes from the analog side, so it is
  // synchronised like the link pins before any logic trusts it.
  reg rext_s1_q;
  reg rext_s2_q;
  always @(posedge ref_clk) begin
    if (!rstn) begin
      rext_s1_q <= 1'b0;
      rext_s2_q <= 1'b0;
    end else begin
      rext_s1_q <= rext_low;
      rext_s2_q <= rext_s1_q;
    end
  end

  // Shutdown conditions common to all channels.
  wire all_off = (!command_config[`SGD_BIT_REXT] && rext_s2_q) ||
    wdog_trip_q;

  // Per-channel comparators; odd group lags one cycle for stagger.
  reg [15:0] pwm_q;
  reg [7:0] odd_dly_q;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_ch
      always @(posedge ref_clk) begin
        if (!rstn) begin
          pwm_q[g] <= 1'b0;
        end else begin
          pwm_q[g] <= !all_off && (cmp_pos < gen_q[g]);
        end
      end
      if ((g % 2) == 1) begin : g_lag
        // One extra flop is the nearest step to the group skew at this
        // clock; a purely digital delay was preferred over an analog one.
        always @(posedge ref_clk) begin
          if (!rstn) begin
            odd_dly_q[g / 2] <= 1'b0;
          end else begin
            odd_dly_q[g / 2] <= pwm_q[g];
          end
        end
      end
      always @(posedge ref_clk) begin
        if (!rstn) begin
          channel_outputs[g] <= 1'b0;
        end else if ((g % 2) == 0) begin
          channel_outputs[g] <= pwm_q[g];
        end else begin
          channel_outputs[g] <= odd_dly_q[g / 2] & ~all_off;
        end
      end
    end
  endgenerate

  // Analog controls and serial output registers.
  // Registering these keeps every top-level output glitch free; the
  // cost is one cycle between a command write and the analog side.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      serial_out <= 1'b0;
      global_current_gain <= 6'h2B;
      short_threshold <= 2'h0;
      power_save <= 1'b0;
    end else begin
      serial_out <= readback_q ? chain_q[`SGD_CHAIN_W-1] :
        chain_q[15];
      global_current_gain <= command_config[9:4];
      short_threshold <= command_config[3:2];
      power_save <= command_config[`SGD_BIT_ZSAVE] &&
        (gen_flat == 256'h0);
    end
  end

endmodule
`default_nettype wire

// File: sgd_dimmer_bench.sv
// Self-checking bench for the grayscale dimmer.
`timescale 1ns/1ps
`default_nettype none
module sgd_dimmer_bench;
  logic ref_clk, rstn, rext_low;
  wire latch_strobe, serial_in, shift_clock, grayscale_clock, serial_out;
  wire [15:0] channel_outputs, command_config;
  wire [5:0] global_current_gain;
  wire [1:0] short_threshold;
  wire power_save;
  int mismatches, total_checks;
  logic [15:0] seen;
  // Writes; the second uses an ignored count of four.
  logic [15:0] wv[4] = '{16'h8C04, 16'h97F8, 16'h97F8, 16'h97FC};
  logic [15:0] cv[4] = '{16'h8C04, 16'h8C04, 16'h97F8, 16'h97FC};
  int ec[4] = '{10, 4, 11, 10};
  // Free-running 20 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  sgd_host_model sgd_host_model_i (.ref_clk(ref_clk),
    .latch_strobe(latch_strobe), .serial_in(serial_in),
    .shift_clock(shift_clock), .grayscale_clock(grayscale_clock),
    .serial_out(serial_out));
  sgd_dimmer sgd_dimmer_i (.ref_clk(ref_clk), .rstn(rstn),
    .latch_strobe(latch_strobe), .serial_in(serial_in),
    .shift_clock(shift_clock), .grayscale_clock(grayscale_clock),
    .serial_out(serial_out), .rext_low(rext_low),
    .channel_outputs(channel_outputs),
    .global_current_gain(global_current_gain),
    .short_threshold(short_threshold), .power_save(power_save),
    .command_config(command_config));
  // Four-state compare so an unknown never passes.
  task automatic check(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s", $time, what);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run needs well under a millisecond.
  initial begin
    #1000000;
    mismatches++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    rstn = 1'b0;
    rext_low = 1'b0;
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    check(command_config, 16'h02B0, "reset command");
    check(global_current_gain, 6'h2B, "reset gain");
    check({short_threshold, channel_outputs}, 0, "reset outs");
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      sgd_host_model_i.shift_word(wv[k], seen);
      if (k > 0) check(seen, wv[k-1], "cascade output");
      sgd_host_model_i.strobe(ec[k]);
      check(command_config, cv[k], "command word");
      check({global_current_gain, short_threshold}, cv[k][9:2], "gain");
    end
    $display("test command done");
    // Sixteen-latch frame, channel 15 first; odd channels at full scale.
    for (int j = 0; j < 16; j++) begin
      sgd_host_model_i.shift_word(j[0] ? 16'h0000 : 16'hFFFF, seen);
      sgd_host_model_i.strobe(j % 2);
    end
    check(channel_outputs, 16'h0000, "data latch only");
    sgd_host_model_i.strobe(2);
    sgd_host_model_i.gs(8);
    check(channel_outputs, 16'hAAAA, "frame shown");
    rext_low = 1'b1;
    repeat (8) @(negedge ref_clk);
    check(channel_outputs, 16'h0000, "low rext off");
    rext_low = 1'b0;
    sgd_host_model_i.gs(2);
    check(channel_outputs, 16'hAAAA, "rext released");
    $display("test frame done");
    // Readback: channel 15 comes out first, then the normal tap returns.
    sgd_host_model_i.strobe(6);
    sgd_host_model_i.shift_word(16'hFFFF, seen);
    check(seen, 16'hFFFF, "readback channel 15");
    sgd_host_model_i.strobe(8);
    check(serial_out, 1'b1, "normal tap back");
    $display("test readback done");
    wrap_up();
  end
endmodule
`default_nettype wire

// File: sgd_dimmer_monitor.sv
// Port checker for the grayscale dimmer, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "sgd_defs.vh"
module sgd_dimmer_monitor (
  // Clock and reset.
  input wire ref_clk,
  input wire rstn,
  // Link pins and status.
  input wire latch_strobe,
  input wire serial_in,
  input wire shift_clock,
  input wire grayscale_clock,
  input wire serial_out,
  input wire rext_low,
  // Outputs of the dimmer.
  input wire [15:0] channel_outputs,
  input wire [5:0] global_current_gain,
  input wire [1:0] short_threshold,
  input wire power_save,
  input wire [15:0] command_config
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Eight quiet cycles cover the pin synchroniser and decode latency.
  sequence s_link_idle;
    ($stable(shift_clock) && $stable(latch_strobe)) [*8];
  endsequence
  sequence s_gs_idle;
    ($stable(grayscale_clock) && $stable(latch_strobe)
      && $stable(rext_low) && !command_config[13]) [*8];
  endsequence
  AST_CMD_RESET: assert property ($rose(rstn) |->
    command_config == `SGD_CMD_RESET) else $error("bad command reset");
  AST_OUT_RESET: assert property ($rose(rstn) |->
    channel_outputs == 16'h0000 && !power_save) else $error("bad out reset");
  AST_GAIN_MAP: assert property ($stable(command_config) |->
    global_current_gain == command_config[9:4]) else $error("gain");
  AST_THRESH_MAP: assert property ($stable(command_config) |->
    short_threshold == command_config[3:2]) else $error("threshold");
  AST_CMD_HOLD: assert property ($stable(latch_strobe) [*8] |=>
    $stable(command_config)) else $error("command moved");
  AST_SOUT_HOLD: assert property (s_link_idle |=>
    $stable(serial_out)) else $error("serial out moved");
  AST_OUT_FREEZE: assert property (s_gs_idle |=>
    $stable(channel_outputs)) else $error("outputs moved");
  AST_REXT_OFF: assert property (
    (rext_low && !command_config[14]) [*6] |-> channel_outputs == 16'h0000)
    else $error("outputs on at low rext");
  AST_PSAVE_OFF: assert property (
    !command_config[1] && !$past(command_config[1]) |-> !power_save)
    else $error("power save while disabled");
endmodule
bind sgd_dimmer sgd_dimmer_monitor sgd_dimmer_monitor_i (
  .ref_clk(ref_clk), .rstn(rstn), .latch_strobe(latch_strobe),
  .serial_in(serial_in), .shift_clock(shift_clock),
  .grayscale_clock(grayscale_clock), .serial_out(serial_out),
  .rext_low(rext_low), .channel_outputs(channel_outputs),
  .global_current_gain(global_current_gain),
  .short_threshold(short_threshold), .power_save(power_save),
  .command_config(command_config));
`default_nettype wire

// File: sgd_host_model.sv
// Host controller model driving the dimmer's serial and grayscale pins.
`timescale 1ns/1ps
`default_nettype none
module sgd_host_model (
  // Pacing clock.
  input wire ref_clk,
  // Pins toward the dimmer.
  output logic latch_strobe,
  output logic serial_in,
  output logic shift_clock,
  output logic grayscale_clock,
  // Cascade output.
  input wire serial_out
);
  // Pins idle low; the shift clock stands still between frames.
  initial begin
    latch_strobe = 1'b0;
    serial_in = 1'b0;
    shift_clock = 1'b0;
    grayscale_clock = 1'b0;
  end
  // Pins only move at falling edges, away from the sampling edge.
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Bits go MSB first, stable around the rising shift edge; 400 ns period.
  task automatic shift_word(input logic [15:0] w, output logic [15:0] seen);
    for (int i = 15; i >= 0; i--) begin
      serial_in = w[i];
      wait_n(4);
      seen[i] = serial_out;
      shift_clock = 1'b1;
      wait_n(4);
      shift_clock = 1'b0;
      serial_in = ~w[i]; // Hold has run out, so the line shows garbage.
    end
  endtask
  // Strobe high with n shift edges selects the instruction.
  task automatic strobe(input int n);
    latch_strobe = 1'b1;
    wait_n(4);
    repeat (n) begin
      shift_clock = 1'b1;
      wait_n(4);
      shift_clock = 1'b0;
      wait_n(4);
    end
    latch_strobe = 1'b0;
    wait_n(8);
  endtask
  // Both grayscale edges count, so each toggle is one step.
  task automatic gs(input int n);
    repeat (n) begin
      wait_n(4);
      grayscale_clock = ~grayscale_clock;
    end
    wait_n(8);
  endtask
endmodule
`default_nettype wire
